/* logic/acs_cfg.svh */
/*
 * Register offsets, field positions, codes and timing constants of the
 * ADC calibration sequencer.
 * Assumes inclusion by bare name from the package; the design module uses its macros without including it.
 */
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register offsets on the plain register port
`define ACS_OFS_CHSEL      4'h0
`define ACS_OFS_CALCTL     4'h1
`define ACS_OFS_ACQ        4'h2
`define ACS_OFS_CLKDIV     4'h3
`define ACS_OFS_IRQ_STAT   4'h4
`define ACS_OFS_IRQ_CLR    4'h5
`define ACS_OFS_IRQ_EN     4'h6
`define ACS_OFS_CALSTAT    4'h7

// Channel select codes
`define ACS_CS_EXT_CH0     4'h0
`define ACS_CS_EXT_CH1     4'h1
`define ACS_CS_INT_ANALOG_GROUND    4'hb
`define ACS_CS_INT_VREF    4'hc

// Calibration control fields and start codes
`define ACS_CTL_BUSY_BIT   7
`define ACS_CTL_GAIN_BIT   1
`define ACS_CTL_START_OFS  8'h25
`define ACS_CTL_START_GAIN 8'h27
`define ACS_CTL_CMD_MASK   8'h7f

// Cycle timing
`define ACS_BITS_PER_CAL   8'h0e
`define ACS_SAR_CLKS       8'h10
`define ACS_AVG_CAL        8'h1f

// Reset values
`define ACS_RST_CHSEL      4'h0
`define ACS_RST_ACQ        8'h04
`define ACS_RST_CLKDIV     8'h1f
`define ACS_RST_IRQ_EN     2'h0

// Sticky event positions
`define ACS_EV_DONE        0
`define ACS_EV_REJECT      1

`endif

/* logic/acs_pkg.sv */
/*
 * Types of the ADC calibration sequencer.
 * Assumes acs_cfg.svh is on the include path.
 */
`include "acs_cfg.svh"

package acs_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      ACS_IDLE   = 2'b00,
      ACS_SAMPLE = 2'b01,
      ACS_FINISH = 2'b10
   } acs_state_t;

   // Calibration kind
   typedef enum logic [1:0] {
      ACS_KIND_DEV_OFS = 2'b00,
      ACS_KIND_DEV_GAIN = 2'b01,
      ACS_KIND_SYS_OFS = 2'b10,
      ACS_KIND_SYS_GAIN = 2'b11
   } acs_kind_t;

endpackage : acs_pkg

/* logic/acs_sequencer.sv */
/*
 * ADC calibration sequencer: registers, converter clock divider,
 * calibration cycle timer, busy flag, input routing and interrupt.
 * Assumes a single 40 MHz clock, synchronous active-high reset, and a
 * register master that never issues read and write in one cycle.
 * Software keeps 16 plus the acquisition count below 256; a larger sum
 * wraps the conversion length and shortens the cycle.
 */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Channel select 0CH routes the internal reference for device gain.
// - Channel select 00H routes input channel 0 for system offset.
// - Writing 25H to calibration control starts a 31-average offset cal.
// - Channel select 01H routes input channel 1 for system gain.
// - Writing 27H to calibration control starts a 31-average gain cal.
// - A cycle lasts 14 x converter clock x averages x (16 + acquisition).
// - Busy at bit 7 rises at cycle start and clears only at its end.
// - Channel select 1011 routes internal analog ground for offset.
module acs_sequencer
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       SRST,
   // Register port
   input  wire logic [3:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output var  logic [7:0] RDATA,
   // Converter side
   output var  logic [3:0] MUX_SEL,
   output var  logic       CAL_ACTIVE,
   output var  logic       CAL_GAIN,
   output var  logic       CONV_CLK_EN,
   // Interrupt
   output var  logic       IRQ
);

   // Configuration and sequencing state
   acs_state_t  state_r;
   logic [3:0]  chsel_r;
   logic [7:0]  acq_r;
   logic [7:0]  clkdiv_r;
   logic [7:0]  div_cnt_r;
   logic        conv_tick;
   logic [7:0]  bitclk_r;     // converter clocks within one conversion
   logic [4:0]  avg_r;        // samples done for the current bit
   logic [3:0]  bit_r;        // result bits done
   logic        gain_r;
   logic        busy_r;
   logic [1:0]  irq_stat_r;
   logic [1:0]  irq_en_r;
   logic        ev_done;
   logic        ev_reject;
   logic        wr_ctl;
   logic        start_ok;
   logic [7:0]  conv_len;
   acs_kind_t   kind_r;
   // Sequencer decode
   acs_state_t  state_nxt;
   logic        sampling;
   logic        conv_last;    // last converter clock of a conversion
   logic        avg_last;     // last average of a result bit
   logic        bit_last;     // last result bit of the cycle
   logic        cycle_last;
   logic        wr_clr;

   // Legal calibration input for the requested kind
   function automatic logic input_ok(input logic [3:0] cs,
                                     input logic       gain);
      if (gain)
         input_ok = (cs == `ACS_CS_INT_VREF)
                  || (cs == `ACS_CS_EXT_CH1);
      else
         input_ok = (cs == `ACS_CS_INT_ANALOG_GROUND)
                  || (cs == `ACS_CS_EXT_CH0);
   endfunction : input_ok

   // External inputs carry system calibration, internal ones device
   function automatic acs_kind_t kind_of(input logic [3:0] cs,
                                         input logic       gain);
      kind_of = acs_kind_t'({cs[3] == 1'b0, gain});
   endfunction : kind_of

   // Strobe aimed at one register offset
   function automatic logic hit(input logic       strobe,
                                input logic [3:0] addr,
                                input logic [3:0] ofs);
      hit = strobe && (addr == ofs);
   endfunction : hit

   // Register strobes decoded once
   assign wr_ctl   = hit(WR, ADDR, `ACS_OFS_CALCTL);
   assign wr_clr   = hit(WR, ADDR, `ACS_OFS_IRQ_CLR);
   // Start taken only when idle, with a known code and a matching input
   assign start_ok = wr_ctl && !busy_r
                   && ((WDATA == `ACS_CTL_START_OFS)
                       || (WDATA == `ACS_CTL_START_GAIN))
                   && input_ok(chsel_r, WDATA[`ACS_CTL_GAIN_BIT]);
   // A refused command with any of bits 6:0 set is flagged so a lost start is visible
   assign ev_reject = wr_ctl && !start_ok
                    && ((WDATA & `ACS_CTL_CMD_MASK) != 8'h00);
   // Sixteen SAR clocks plus the programmed acquisition
   assign conv_len  = 8'(`ACS_SAR_CLKS + acq_r);

   // Conversion setup; frozen while busy so a running cycle keeps its
   // input and timing even if software writes in mid-cycle
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         chsel_r  <= `ACS_RST_CHSEL;
         acq_r    <= `ACS_RST_ACQ;
         clkdiv_r <= `ACS_RST_CLKDIV;
      end else if (WR && !busy_r) begin
         case (ADDR)
            `ACS_OFS_CHSEL:  chsel_r <= WDATA[3:0];
            `ACS_OFS_ACQ:    acq_r <= WDATA;
            `ACS_OFS_CLKDIV: clkdiv_r <= WDATA;
            default: ;
         endcase
      end
   end

   // Interrupt enable, writable at any time
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         irq_en_r <= `ACS_RST_IRQ_EN;
      else if (hit(WR, ADDR, `ACS_OFS_IRQ_EN))
         irq_en_r <= WDATA[1:0];
   end

   // Converter clock enable divider, free running; a tick every
   // divisor + 1 reference clocks. A smaller divisor written mid-count
   // takes effect at once, since the compare is greater-or-equal
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         div_cnt_r <= 8'h00;
      else if (div_cnt_r >= clkdiv_r)
         div_cnt_r <= 8'h00;
      else
         div_cnt_r <= div_cnt_r + 8'h01;
   end
   assign conv_tick = (div_cnt_r >= clkdiv_r);

   // Boundaries of a conversion, of a bit's averages and of the cycle
   assign sampling   = (state_r == ACS_SAMPLE);
   assign conv_last  = !(bitclk_r + 8'h01 < conv_len);
   assign avg_last   = !(avg_r + 5'h01 < 5'(`ACS_AVG_CAL));
   assign bit_last   = !(bit_r + 4'h1 < 4'(`ACS_BITS_PER_CAL));
   assign cycle_last = sampling && conv_tick && conv_last && avg_last
                       && bit_last;

   // Next state: idle until a start is taken, sample until the last
   // tick of the last conversion, then one finish cycle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ACS_IDLE: begin
            if (start_ok)
               state_nxt = ACS_SAMPLE;
         end
         ACS_SAMPLE: begin
            if (cycle_last)
               state_nxt = ACS_FINISH;
         end
         ACS_FINISH: begin
            state_nxt = ACS_IDLE;
         end
         default: begin
            state_nxt = ACS_IDLE;
         end
      endcase
   end

   // Sequencer state register
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         state_r <= ACS_IDLE;
      else
         state_r <= state_nxt;
   end

   // Converter clocks within one conversion: 16 plus acquisition
   always_ff @(posedge REF_CLK) begin
      if (SRST || start_ok)
         bitclk_r <= 8'h00;
      else if (sampling && conv_tick) begin
         if (conv_last)
            bitclk_r <= 8'h00;
         else
            bitclk_r <= bitclk_r + 8'h01;
      end
   end

   // Samples averaged for the current result bit
   always_ff @(posedge REF_CLK) begin
      if (SRST || start_ok)
         avg_r <= 5'h00;
      else if (sampling && conv_tick && conv_last) begin
         if (avg_last)
            avg_r <= 5'h00;
         else
            avg_r <= avg_r + 5'h01;
      end
   end

   // Result bits done; holds its count until the next start
   always_ff @(posedge REF_CLK) begin
      if (SRST || start_ok)
         bit_r <= 4'h0;
      else if (sampling && conv_tick && conv_last && avg_last
               && !bit_last)
         bit_r <= bit_r + 4'h1;
   end

   // Busy spans the whole cycle, not each conversion inside it
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         busy_r <= 1'b0;
      else if (start_ok)
         busy_r <= 1'b1;
      else if (state_r == ACS_FINISH)
         busy_r <= 1'b0;
   end

   // Kind of the accepted request, kept for outputs and readback
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         gain_r <= 1'b0;
         kind_r <= ACS_KIND_DEV_OFS;
      end else if (start_ok) begin
         gain_r <= WDATA[`ACS_CTL_GAIN_BIT];
         kind_r <= kind_of(chsel_r, WDATA[`ACS_CTL_GAIN_BIT]);
      end
   end

   // Done event marks the single finish cycle
   assign ev_done = (state_r == ACS_FINISH);

   // Sticky events; a new event beats a clear in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         irq_stat_r <= 2'h0;
      else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `ACS_EV_DONE && ev_done)
                || (i == `ACS_EV_REJECT && ev_reject))
               irq_stat_r[i] <= 1'b1;
            else if (wr_clr && WDATA[i])
               irq_stat_r[i] <= 1'b0;
         end
      end
   end

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         RDATA <= 8'h00;
      else if (RD) begin
         case (ADDR)
            `ACS_OFS_CHSEL:    RDATA <= {4'h0, chsel_r};
            // Busy polled here by software
            `ACS_OFS_CALCTL:   RDATA <= {busy_r, 5'h00, gain_r, 1'b0};
            `ACS_OFS_ACQ:      RDATA <= acq_r;
            `ACS_OFS_CLKDIV:   RDATA <= clkdiv_r;
            `ACS_OFS_IRQ_STAT: RDATA <= {6'h00, irq_stat_r};
            `ACS_OFS_IRQ_EN:   RDATA <= {6'h00, irq_en_r};
            // Status: busy, state and calibration kind
            `ACS_OFS_CALSTAT:  RDATA <= {busy_r, 1'b0, state_r,
                                         2'h0, kind_r};
            default:           RDATA <= 8'h00;
         endcase
      end else
         RDATA <= 8'h00;
   end

   // Converter side outputs, all registered; the mux copy trails the
   // select register by one cycle, hidden because the select is frozen
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         MUX_SEL     <= 4'h0;
         CAL_ACTIVE  <= 1'b0;
         CAL_GAIN    <= 1'b0;
         CONV_CLK_EN <= 1'b0;
      end else begin
         MUX_SEL     <= chsel_r;
         CAL_ACTIVE  <= busy_r;
         CAL_GAIN    <= gain_r;
         CONV_CLK_EN <= conv_tick && sampling;
      end
   end

   // Level interrupt, high while an enabled sticky event is pending
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         IRQ <= 1'b0;
      else
         IRQ <= |(irq_stat_r & irq_en_r);
   end

endmodule : acs_sequencer

`default_nettype wire

/* test/acs_checker.sv */
/* Port checker of the calibration sequencer.
   Assumes the bind below and the sequencer's own ports. */
`timescale 1ns/10ps
`default_nettype none
module acs_checker (
   // Clock and reset
   input wire logic       REF_CLK,
   input wire logic       SRST,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // Converter side
   input wire logic [3:0] MUX_SEL,
   input wire logic       CAL_ACTIVE,
   input wire logic       CAL_GAIN,
   input wire logic       CONV_CLK_EN
);
   logic [13:0] len_r;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // Busy length; saturates so slow default cycles cannot wrap
   always_ff @(posedge REF_CLK)
      if (SRST || !CAL_ACTIVE) len_r <= 14'h0;
      else if (len_r != 14'h3fff) len_r <= len_r + 14'h1;
   a_rdata_idle_zero: assert property (
      !$past(RD) |-> RDATA == 8'h0) else $error("stray read data");
   a_start_by_code: assert property (
      $rose(CAL_ACTIVE) |-> $past(WR, 2) && $past(ADDR, 2) == 4'h1
      && $past(WDATA[6:0], 2) inside {7'h25, 7'h27})
      else $error("cycle began without start code");
   a_offset_input: assert property (
      $rose(CAL_ACTIVE) && !$past(WDATA[1], 2)
      |-> MUX_SEL inside {4'h0, 4'hb}) else $error("bad offset input");
   a_gain_input: assert property (
      $rose(CAL_ACTIVE) && $past(WDATA[1], 2)
      |-> MUX_SEL inside {4'h1, 4'hc}) else $error("bad gain input");
   a_cycle_min_span: assert property (
      $fell(CAL_ACTIVE) |-> len_r >= 14'h1b20) else $error("cycle short");
   a_busy_bit_read: assert property (
      $past(RD) && $past(ADDR) == 4'h1 |-> RDATA[7] == CAL_ACTIVE)
      else $error("busy bit differs from cycle");
   a_kind_held: assert property (
      CAL_ACTIVE && $past(CAL_ACTIVE) |-> $stable(CAL_GAIN))
      else $error("kind changed in cycle");
   a_route_held: assert property (
      CAL_ACTIVE && $past(CAL_ACTIVE) |-> $stable(MUX_SEL))
      else $error("input changed in cycle");
   a_tick_in_cycle: assert property (
      CONV_CLK_EN |-> CAL_ACTIVE) else $error("tick outside cycle");
   // Main scenarios
   c_offset_cal: cover property ($rose(CAL_ACTIVE) && !CAL_GAIN);
   c_gain_cal: cover property ($rose(CAL_ACTIVE) && CAL_GAIN);
   c_cal_done: cover property ($fell(CAL_ACTIVE));
endmodule : acs_checker
bind acs_sequencer acs_checker u_chk (.REF_CLK, .SRST, .ADDR, .WDATA,
   .WR, .RD, .RDATA, .MUX_SEL, .CAL_ACTIVE, .CAL_GAIN, .CONV_CLK_EN);
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench of the calibration sequencer.
   Assumes the package and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench import acs_pkg::*;;
   logic        clk = 0, srst = 1, wr = 0, rd = 0, rd_q = 0;
   logic [3:0]  addr = 4'h0, mux;
   logic [7:0]  wdata = 8'h0, rdata, d;
   logic        act, gain, tick, irq;
   logic [8:0]  q[$];
   logic [11:0] cal[4] = '{12'hb25, 12'hc27, 12'h025, 12'h127};
   int          n_errors = 0, n_checks = 0, seed = 85293, n;
   time         t0;
   acs_sequencer u_dut (.REF_CLK(clk), .SRST(srst), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MUX_SEL(mux),
      .CAL_ACTIVE(act), .CAL_GAIN(gain), .CONV_CLK_EN(tick), .IRQ(irq));
   always #12.5 clk = ~clk;
   task automatic chk(input logic [7:0] e, input logic [7:0] a);
      n_checks++;
      if (a !== e) begin
         n_errors++;
         $display("[FAIL] %0t exp %h got %h", $time, e, a);
      end
   endtask : chk
   task automatic wr8(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr8
   // Bit 8 of the note marks a read whose data is checked
   task automatic rd8(input logic [3:0] a, input logic [8:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd8
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // Read data stand one cycle; compare them with the oldest note
   always @(posedge clk) begin
      if (rd_q && q.size() > 0) begin
         if (q[0][8])
            chk(q[0][7:0], rdata);
         void'(q.pop_front());
      end
      rd_q <= rd;
   end
   // Hang guard, well past four short cycles
   initial begin
      #(25 * 40000);
      n_errors++;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rd8(4'h2, 9'h104);
      rd8(4'h3, 9'h11f);
      rd8(4'h6, 9'h100);
      rd8(4'h8 | 4'($random(seed)), 9'h100);
      $display("test reset values done");
      // Shortest timing keeps each cycle near 6944 clocks
      wr8(4'h2, 8'h00);
      wr8(4'h3, 8'h00);
      wr8(4'h0, 8'h00);
      wr8(4'h1, 8'h27);
      rd8(4'h4, 9'h102);
      chk(8'h0, {6'h0, act, irq});
      chk(8'h0, {7'h0, tick});
      wr8(4'h6, 8'h03);
      rd8(4'h4, 9'h102);
      chk(8'h1, {7'h0, irq});
      wr8(4'h5, 8'h02);
      rd8(4'h4, 9'h100);
      chk(8'h0, {7'h0, irq});
      $display("test refused start done");
      foreach (cal[i]) begin
         wr8(4'h0, {4'h0, cal[i][11:8]});
         wr8(4'h1, cal[i][7:0]);
         t0 = $time;
         wr8(4'h0, 8'($random(seed)));
         wr8(4'h1, 8'h25);
         @(negedge clk);
         chk({4'h1, cal[i][11:8]}, {3'h0, act, mux});
         chk({7'h0, cal[i][1]}, {7'h0, gain});
         chk(8'h1, {7'h0, tick});
         rd8(4'h7, {1'b1, 8'h90 | 8'(i)});
         rd8(4'h1, {1'b1, 8'h80 | (cal[i][7:0] & 8'h02)});
         d = 8'h80;
         // Software waits on the busy bit
         while (d[7])
            rd8(4'h1, 9'h0);
         n = int'(($time - t0) / 25);
         chk(8'h1, {7'h0, n inside {[32'h1b20:32'h1b28]}});
         rd8(4'h4, 9'h103);
         wr8(4'h5, 8'h03);
         rd8(4'h4, 9'h100);
         $display("test calibration %0d done", i);
      end
      stop_test;
   end
endmodule : testbench
`default_nettype wire
